// [coex_pkg.sv]
package coex_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] COEXISTENCE_CONTROL_REG_OFS = 8'h00;
   localparam logic [7:0] LINK_IRQ_OFS  = 8'h04;
   localparam logic [7:0] LINK_CTRL_OFS = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // coexistence_control_reg fields
   localparam int LINK_EN_LSB   = 0;
   localparam int LINK_EN_W     = 4;
   localparam int FSK_LINK_BIT  = 3;
   localparam int TX_QUAL_BIT   = 4;
   localparam int RX_QUAL_BIT   = 5;
   localparam int OVRD_EN_BIT   = 6;
   localparam int OVRD_VAL_BIT  = 7;
   localparam int INVERT_BIT    = 8;
   localparam int PIN_SEL_LSB   = 9;
   localparam int PIN_SEL_W     = 3;
   localparam int SEEN_BIT      = 16;
   localparam int TX_ABORT_BIT  = 17;
   localparam int RX_ABORT_BIT  = 18;
   localparam int RAW_PIN_BIT   = 20;

   // link_irq_status_reg fields
   localparam int LOCK_LOSS_BIT = 0;
   localparam int SEQ_DONE_BIT  = 1;

   // link control fields
   localparam int START_TX_BIT  = 0;
   localparam int START_RX_BIT  = 1;
   localparam int STOP_BIT      = 2;
   localparam int PLL_EN_BIT    = 3;
   localparam int LL_STATE_LSB  = 8;
   localparam int SEQ_STATE_LSB = 12;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [3:0] LINK_EN_RST  = 4'h0;
   localparam logic [2:0] PIN_SEL_RST  = 3'h0;
   localparam logic       CFG_BIT_RST  = 1'b0;
   localparam logic       FLAG_RST     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS    = 10;
   localparam int WARMDOWN_TIME_NS = 2000;
   localparam int WARMDOWN_CYCLES  = (WARMDOWN_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     WARMDOWN_TIME_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // states
   typedef enum logic [1:0] {
      LL_IDLE     = 2'b00,
      LL_TX       = 2'b01,
      LL_RX       = 2'b10,
      LL_WARMDOWN = 2'b11
   } ll_state_t;

   typedef enum logic [1:0] {
      SEQ_IDLE     = 2'b00,
      SEQ_RUN      = 2'b01,
      SEQ_WARMDOWN = 2'b10
   } seq_state_t;

endpackage

// [veto_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module veto_pin_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic ce,
   // pin and synchronised level
   input  wire logic pin,
   output var  logic level
);

   logic stage1;
   logic stage2;
   logic stage3;

   // third stage filters a metastable settle; level moves only when two agree
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level  <= 1'b0;
      end else if (ce) begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level <= stage3;
         end
      end
   end

endmodule

`default_nettype wire

// [coex_veto_abort_logic.sv]
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - veto from the master pauses radio traffic on the enabled link layers; release allows it again
// - veto aborting enabled per engine; fsk uses enable bit 3
// - fsk enable bit 0 means veto transitions are ignored by fsk
// - fsk enable bit 1 means a veto rising edge aborts the active sequence
// - tx aborted only if tx qualifier is 1 and tx request high
// - rx aborted only if rx qualifier is 1 and rx request high
// - veto abort drives the pll-abort path and sets the lock-loss flag
// - pll abort and veto abort have separate enables; veto status kept apart
// - each veto rising edge sets veto-seen, then abort conditions are checked
// - with any condition false only veto-seen is set
// - all conditions true set tx or rx abort flag and signal lock loss
// - after abort link layer waits in warm-down with request dropped until idle
// - sequence manager idle again sets sequence-done flag, link layer idles
// - lock-loss, veto-seen and direction abort flags stay set afterwards
// - veto-seen sets on every veto assertion, clears only by writing one
// - read-only bit shows raw level of the selected veto pin
// - override enable replaces the pin by the override value
// - invert bit inverts the selected pin before use
// - three-bit field selects which pin feeds the veto
// - four-bit field selects which link layers receive the veto
// - link layers use veto directly and drop their own tx or rx enables
module coex_veto_abort_logic #(
   parameter int VETO_PINS       = 8,
   parameter int WARMDOWN_CYCLES = coex_pkg::WARMDOWN_CYCLES
) (
   // clock, reset, enable
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output var  logic [31:0]          hrdata,
   output var  logic                 hreadyout,
   output var  logic                 hresp,
   // coexistence pins and pll
   input  wire logic [VETO_PINS-1:0] coex_veto_pin,
   input  wire logic                 pll_unlock,
   // toward the link layers and radio
   output var  logic [3:0]           link_veto,
   output var  logic                 fsk_tx_en,
   output var  logic                 fsk_rx_en
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [VETO_PINS-1:0] sync_pin;
   logic [3:0]           veto_link_enable;
   logic                 veto_tx_abort_qual;
   logic                 veto_rx_abort_qual;
   logic                 veto_override_enable;
   logic                 veto_override_value;
   logic                 veto_invert;
   logic [2:0]           veto_pin_select;
   logic                 pll_abort_enable;
   logic                 veto_seen_flag;
   logic                 veto_tx_aborted_flag;
   logic                 veto_rx_aborted_flag;
   logic                 lock_loss_flag;
   logic                 sequence_done_irq_flag;
   logic                 veto_pin_level;
   logic                 coex_veto;
   logic                 veto_prev;
   logic                 veto_edge;
   logic                 veto_tx_abort;
   logic                 veto_rx_abort;
   logic                 veto_abort;
   logic                 pll_abort_in;
   logic                 dp_write;
   logic                 dp_read;
   logic [7:0]           dp_addr;
   logic                 wr_ctrl;
   logic                 wr_irq;
   logic                 wr_link;
   logic                 start_tx;
   logic                 start_rx;
   logic                 stop_seq;
   logic [31:0]          read_word;
   logic [$clog2(WARMDOWN_CYCLES+1)-1:0] wd_count;
   coex_pkg::ll_state_t  ll_state;
   coex_pkg::seq_state_t seq_state;

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // veto pin path
   for (genvar i = 0; i < VETO_PINS; i++) begin : g_sync
      veto_pin_sync u_sync (
         .core_clk (core_clk),
         .nrst     (nrst),
         .ce       (ce),
         .pin      (coex_veto_pin[i]),
         .level    (sync_pin[i])
      );
   end

   assign veto_pin_level = sync_pin[veto_pin_select];
   assign coex_veto      = veto_override_enable ? veto_override_value
                         : (veto_pin_level ^ veto_invert);
   assign veto_edge      = coex_veto & ~veto_prev;
   // fsk takes the veto edge directly, gated by enable bit 3 and the qualifiers; other engines see it on link_veto
   assign veto_tx_abort  = veto_edge & veto_link_enable[coex_pkg::FSK_LINK_BIT]
                         & veto_tx_abort_qual & fsk_tx_en;
   assign veto_rx_abort  = veto_edge & veto_link_enable[coex_pkg::FSK_LINK_BIT]
                         & veto_rx_abort_qual & fsk_rx_en;
   // pll unlock comes from the on-chip pll, same clock, no synchroniser
   assign pll_abort_in   = veto_abort | (pll_unlock & pll_abort_enable);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         veto_prev  <= 1'b0;
         veto_abort <= 1'b0;
         link_veto  <= 4'h0;
      end else if (ce) begin
         veto_prev  <= coex_veto;
         veto_abort <= veto_tx_abort | veto_rx_abort;
         link_veto  <= veto_link_enable & {4{coex_veto}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: writes zero-wait, reads one wait state
   assign wr_ctrl  = dp_write & reg_hit(dp_addr, coex_pkg::COEXISTENCE_CONTROL_REG_OFS);
   assign wr_irq   = dp_write & reg_hit(dp_addr, coex_pkg::LINK_IRQ_OFS);
   assign wr_link  = dp_write & reg_hit(dp_addr, coex_pkg::LINK_CTRL_OFS);
   assign start_tx = wr_link & hwdata[coex_pkg::START_TX_BIT];
   assign start_rx = wr_link & hwdata[coex_pkg::START_RX_BIT];
   assign stop_seq = wr_link & hwdata[coex_pkg::STOP_BIT];

   always_comb begin
      read_word = 32'h0000_0000;
      if (reg_hit(dp_addr, coex_pkg::COEXISTENCE_CONTROL_REG_OFS)) begin
         read_word[coex_pkg::LINK_EN_LSB +: coex_pkg::LINK_EN_W] = veto_link_enable;
         read_word[coex_pkg::TX_QUAL_BIT]  = veto_tx_abort_qual;
         read_word[coex_pkg::RX_QUAL_BIT]  = veto_rx_abort_qual;
         read_word[coex_pkg::OVRD_EN_BIT]  = veto_override_enable;
         read_word[coex_pkg::OVRD_VAL_BIT] = veto_override_value;
         read_word[coex_pkg::INVERT_BIT]   = veto_invert;
         read_word[coex_pkg::PIN_SEL_LSB +: coex_pkg::PIN_SEL_W] = veto_pin_select;
         read_word[coex_pkg::SEEN_BIT]     = veto_seen_flag;
         read_word[coex_pkg::TX_ABORT_BIT] = veto_tx_aborted_flag;
         read_word[coex_pkg::RX_ABORT_BIT] = veto_rx_aborted_flag;
         read_word[coex_pkg::RAW_PIN_BIT]  = veto_pin_level;
      end else if (reg_hit(dp_addr, coex_pkg::LINK_IRQ_OFS)) begin
         read_word[coex_pkg::LOCK_LOSS_BIT] = lock_loss_flag;
         read_word[coex_pkg::SEQ_DONE_BIT]  = sequence_done_irq_flag;
      end else if (reg_hit(dp_addr, coex_pkg::LINK_CTRL_OFS)) begin
         read_word[coex_pkg::PLL_EN_BIT] = pll_abort_enable;
         read_word[coex_pkg::LL_STATE_LSB +: 2]  = ll_state;
         read_word[coex_pkg::SEQ_STATE_LSB +: 2] = seq_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         dp_write  <= 1'b0;
         dp_read   <= 1'b0;
         dp_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0;
         if (dp_read) begin
            hrdata    <= read_word;
            hreadyout <= 1'b1;
            dp_read   <= 1'b0;
         end else if (hsel && htrans[1] && hready) begin
            // only whole words exist, so hsize does not steer the decode
            dp_addr   <= haddr[7:0];
            dp_write  <= hwrite;
            dp_read   <= ~hwrite;
            hreadyout <= hwrite | (hsize != 3'h2 && hsize == 3'h2);
         end else begin
            dp_write <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         veto_link_enable     <= coex_pkg::LINK_EN_RST;
         veto_tx_abort_qual   <= coex_pkg::CFG_BIT_RST;
         veto_rx_abort_qual   <= coex_pkg::CFG_BIT_RST;
         veto_override_enable <= coex_pkg::CFG_BIT_RST;
         veto_override_value  <= coex_pkg::CFG_BIT_RST;
         veto_invert          <= coex_pkg::CFG_BIT_RST;
         veto_pin_select      <= coex_pkg::PIN_SEL_RST;
         pll_abort_enable     <= coex_pkg::CFG_BIT_RST;
      end else if (ce) begin
         if (wr_ctrl) begin
            veto_link_enable     <= hwdata[coex_pkg::LINK_EN_LSB +: coex_pkg::LINK_EN_W];
            veto_tx_abort_qual   <= hwdata[coex_pkg::TX_QUAL_BIT];
            veto_rx_abort_qual   <= hwdata[coex_pkg::RX_QUAL_BIT];
            veto_override_enable <= hwdata[coex_pkg::OVRD_EN_BIT];
            veto_override_value  <= hwdata[coex_pkg::OVRD_VAL_BIT];
            veto_invert          <= hwdata[coex_pkg::INVERT_BIT];
            veto_pin_select      <= hwdata[coex_pkg::PIN_SEL_LSB +: coex_pkg::PIN_SEL_W];
         end
         if (wr_link) begin
            pll_abort_enable <= hwdata[coex_pkg::PLL_EN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         veto_seen_flag         <= coex_pkg::FLAG_RST;
         veto_tx_aborted_flag   <= coex_pkg::FLAG_RST;
         veto_rx_aborted_flag   <= coex_pkg::FLAG_RST;
         lock_loss_flag         <= coex_pkg::FLAG_RST;
         sequence_done_irq_flag <= coex_pkg::FLAG_RST;
      end else if (ce) begin
         veto_seen_flag <= (veto_seen_flag & ~(wr_ctrl & hwdata[coex_pkg::SEEN_BIT]))
                         | veto_edge;
         veto_tx_aborted_flag <= (veto_tx_aborted_flag
                               & ~(wr_ctrl & hwdata[coex_pkg::TX_ABORT_BIT]))
                               | veto_tx_abort;
         veto_rx_aborted_flag <= (veto_rx_aborted_flag
                               & ~(wr_ctrl & hwdata[coex_pkg::RX_ABORT_BIT]))
                               | veto_rx_abort;
         lock_loss_flag <= (lock_loss_flag & ~(wr_irq & hwdata[coex_pkg::LOCK_LOSS_BIT]))
                         | (pll_abort_in && (ll_state == coex_pkg::LL_TX
                                          || ll_state == coex_pkg::LL_RX));
         sequence_done_irq_flag <= (sequence_done_irq_flag
                                 & ~(wr_irq & hwdata[coex_pkg::SEQ_DONE_BIT]))
                                 | (ll_state == coex_pkg::LL_WARMDOWN
                                    && seq_state == coex_pkg::SEQ_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fsk link layer; software is trusted not to start while vetoed
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ll_state  <= coex_pkg::LL_IDLE;
         fsk_tx_en <= 1'b0;
         fsk_rx_en <= 1'b0;
      end else if (ce) begin
         unique case (ll_state)
            coex_pkg::LL_IDLE: begin
               if (start_tx) begin
                  ll_state  <= coex_pkg::LL_TX;
                  fsk_tx_en <= 1'b1;
               end else if (start_rx) begin
                  ll_state  <= coex_pkg::LL_RX;
                  fsk_rx_en <= 1'b1;
               end
            end
            coex_pkg::LL_TX, coex_pkg::LL_RX: begin
               if (pll_abort_in || stop_seq) begin
                  ll_state  <= coex_pkg::LL_WARMDOWN;
                  fsk_tx_en <= 1'b0;
                  fsk_rx_en <= 1'b0;
               end
            end
            coex_pkg::LL_WARMDOWN: begin
               if (seq_state == coex_pkg::SEQ_IDLE) begin
                  ll_state <= coex_pkg::LL_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequence manager: runs while requested, then a fixed warm-down
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         seq_state <= coex_pkg::SEQ_IDLE;
         wd_count  <= '0;
      end else if (ce) begin
         unique case (seq_state)
            coex_pkg::SEQ_IDLE: begin
               if (fsk_tx_en || fsk_rx_en) begin
                  seq_state <= coex_pkg::SEQ_RUN;
               end
            end
            coex_pkg::SEQ_RUN: begin
               if (!fsk_tx_en && !fsk_rx_en) begin
                  seq_state <= coex_pkg::SEQ_WARMDOWN;
                  wd_count  <= '0;
               end
            end
            coex_pkg::SEQ_WARMDOWN: begin
               if (wd_count == ($clog2(WARMDOWN_CYCLES+1))'(WARMDOWN_CYCLES - 1)) begin
                  seq_state <= coex_pkg::SEQ_IDLE;
               end else begin
                  wd_count <= wd_count + 1'b1;
               end
            end
            default: begin
               seq_state <= coex_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst || !ce);

   sequence s_tx_abort_cause;
      veto_edge && veto_link_enable[3] && veto_tx_abort_qual && fsk_tx_en;
   endsequence

   sequence s_abort_result;
      veto_tx_aborted_flag && veto_abort ##1 ll_state == coex_pkg::LL_WARMDOWN
      && !fsk_tx_en && lock_loss_flag;
   endsequence

   chk_veto_seen_set: assert property (veto_edge |=> veto_seen_flag)
      else $error("veto seen not set");
   chk_tx_abort_path: assert property (s_tx_abort_cause |=> s_abort_result)
      else $error("tx veto abort did not complete");
   chk_disabled_ignore: assert property (
      veto_edge && !veto_link_enable[3] |=> !veto_abort)
      else $error("veto acted while fsk disabled");
   chk_rx_qual_zero: assert property (
      veto_edge && !veto_rx_abort_qual && !fsk_tx_en |=> !veto_abort
      && $stable(veto_rx_aborted_flag) || !veto_rx_aborted_flag)
      else $error("rx aborted with qualifier clear");
   chk_lock_loss_flag: assert property (
      pll_abort_in && fsk_rx_en |=> lock_loss_flag && !fsk_rx_en)
      else $error("lock loss not flagged");
   chk_warmdown_hold: assert property (
      ll_state == coex_pkg::LL_WARMDOWN && seq_state != coex_pkg::SEQ_IDLE
      |=> ll_state == coex_pkg::LL_WARMDOWN)
      else $error("left warm-down early");
   chk_seq_done_flag: assert property (
      ll_state == coex_pkg::LL_WARMDOWN && seq_state == coex_pkg::SEQ_IDLE
      |=> ll_state == coex_pkg::LL_IDLE && sequence_done_irq_flag)
      else $error("sequence end not reported");
   chk_override_value: assert property (
      veto_override_enable && veto_link_enable[0]
      |=> link_veto[0] == $past(veto_override_value))
      else $error("override not applied");
   chk_enable_gating: assert property (
      !veto_link_enable[1] |=> !link_veto[1])
      else $error("veto reached disabled link");

endmodule

`default_nettype wire

// [wlan_veto_model.sv]
`timescale 1ns/1ps
`default_nettype none

module wlan_veto_model (
   // clock
   input  wire logic       core_clk,
   // veto request and pin choice from the bench
   input  wire logic       veto,
   input  wire logic [2:0] sel,
   // pins toward the radio
   output var  logic [7:0] pins
);
   int         seed = 32'hab580aec;
   logic [7:0] wander;

   // unused pins wander every cycle so a wrong select cannot hide
   always @(posedge core_clk) begin
      wander      = 8'($random(seed));
      wander[sel] = veto;
      pins       <= wander;
   end
endmodule

`default_nettype wire

// [test_coex_veto_abort_logic.sv]
`timescale 1ns/1ps
`default_nettype none

module test_coex_veto_abort_logic;
   localparam logic [7:0]  CT = coex_pkg::COEXISTENCE_CONTROL_REG_OFS;
   localparam logic [7:0]  IQ = coex_pkg::LINK_IRQ_OFS;
   localparam logic [7:0]  LC = coex_pkg::LINK_CTRL_OFS;
   localparam logic [31:0] FL = 32'h0007_0000;
   logic        core_clk   = 1'b0;
   logic        nrst       = 1'b0;
   logic        ce         = 1'b1;
   logic        hsel       = 1'b0;
   logic        hwrite     = 1'b0;
   logic        veto       = 1'b0;
   logic        pll_unlock = 1'b0;
   logic [1:0]  htrans     = 2'b00;
   logic [2:0]  sel        = 3'h0;
   logic [31:0] haddr      = 32'h0;
   logic [31:0] hwdata     = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [31:0] c;
   logic        hreadyout;
   logic        hresp;
   logic        fsk_tx_en;
   logic        fsk_rx_en;
   logic [3:0]  link_veto;
   logic [7:0]  pins;
   int          err_total  = 0;
   int          checked    = 0;
   int          cyc        = 0;
   int          seed       = 32'hab580aec;

   // warm-down cut from the default 200 cycles to 40, still long enough to read the wait state back
   coex_veto_abort_logic #(.WARMDOWN_CYCLES(40)) dut (
      .core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .coex_veto_pin(pins), .pll_unlock(pll_unlock), .link_veto(link_veto),
      .fsk_tx_en(fsk_tx_en), .fsk_rx_en(fsk_rx_en));

   wlan_veto_model far (.core_clk(core_clk), .veto(veto), .sel(sel), .pins(pins));

   always #5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (err_total == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // override beats invert, invert acts on the selected pin
   function automatic logic [3:0] exp_veto(input logic [31:0] v);
      logic lvl;
      lvl = v[6] ? v[7] : v[12] ^ v[8];
      return v[3:0] & {4{lvl}};
   endfunction

   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         bus(1'b0, LC, 32'h0);
         if ((rd[13:8] & 6'h33) == 6'h00)
            break;
      end
      chk({26'h0, rd[13:8] & 6'h33}, 32'h0);
   endtask

   task automatic run_abort(input logic rx, input logic en3, input logic q, input logic pll);
      logic        hit;
      logic [1:0]  req;
      logic [31:0] vf;
      hit = pll | (en3 & q);
      req = rx ? 2'b10 : 2'b01;
      vf  = pll ? 32'h0 : {13'h0, rx & en3 & q, ~rx & en3 & q, 1'b1, 16'h0};
      sel <= 3'h5;
      bus(1'b1, CT, {20'h0, 3'h5, 3'h0, q & rx, q & ~rx, en3, 3'h0});
      bus(1'b1, LC, (pll ? 32'h8 : 32'h0) | 32'(req));
      repeat (2) @(posedge core_clk);
      chk({30'h0, fsk_rx_en, fsk_tx_en}, 32'(req));
      if (pll) begin
         pll_unlock <= 1'b1;
         @(posedge core_clk);
         pll_unlock <= 1'b0;
      end else begin
         veto <= 1'b1;
      end
      repeat (10) @(posedge core_clk);
      chk({30'h0, fsk_rx_en, fsk_tx_en}, hit ? 32'h0 : 32'(req));
      bus(1'b0, LC, 32'h0);
      chk({30'h0, rd[9:8]}, hit ? 32'h3 : 32'(req));
      if (!hit)
         bus(1'b1, LC, 32'h4);
      wait_idle();
      bus(1'b0, CT, 32'h0);
      chk(rd & FL, vf);
      bus(1'b0, IQ, 32'h0);
      chk(rd & (hit ? 32'h3 : 32'h1), hit ? 32'h3 : 32'h0);
      veto <= 1'b0;
      repeat (6) @(posedge core_clk);
      bus(1'b1, CT, FL | 32'h0a00);
      bus(1'b1, IQ, 32'h3);
      bus(1'b0, CT, 32'h0);
      chk(rd & FL, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, 8'h0c, 32'hffffffff);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // random routing: enables, override, invert, pin choice, pin level
      for (int i = 0; i < 16; i++) begin
         c = $random(seed);
         sel  <= c[11:9];
         veto <= c[12];
         bus(1'b1, CT, c & 32'h0fcf);
         repeat (8) @(posedge core_clk);
         chk({28'h0, link_veto}, {28'h0, exp_veto(c)});
         bus(1'b0, CT, 32'h0);
         chk(32'(rd[coex_pkg::RAW_PIN_BIT]), 32'(c[12]));
      end
      // frozen clock enable: a flipped pin must not reach the link outputs
      ce   <= 1'b0;
      veto <= ~c[12];
      repeat (8) @(posedge core_clk);
      chk({28'h0, link_veto}, {28'h0, exp_veto(c)});
      ce   <= 1'b1;
      veto <= 1'b0;
      sel  <= 3'h5;
      repeat (8) @(posedge core_clk);
      // pin 5 stays selected so the wandering pins cannot raise the veto
      bus(1'b1, CT, FL | 32'h0a00);
      // both directions, every enable and qualifier pair, then plain pll aborts
      for (int k = 0; k < 10; k++)
         run_abort(k[0], k[1], k[2], k[3]);
      conclude();
   end
endmodule

`default_nettype wire
